// ---- hw/prog_mem_pkg.sv ----
// Shared constants and types for the program memory access unit.
// Notes on behaviour
// - Program memory holds 16-bit words, 2K, 4K or 8K deep by variant.
// - After reset execution starts by fetching word address 0000H.
// - A full table address joins the low and high table pointers.
// - Standard table reads write sector 0; long forms write any sector.
// - A table read writes the word's low byte to the named data location.
// - A table read loads the word's high byte into the readable hold register.
// - Every table instruction takes two instruction cycles.
// - Page-relative table reads use the pointer as an offset within a page.
// - Programming port carries data both ways on one line with a programmer clock.
// - Flash and data EEPROM can both be written through the programming port.
// - Debug variant has debug data and clock pins; shared pin functions are off.
// - In the debug variant those pins still serve flash programming.
// - Program counter changes cost one extra cycle, a dummy replacing the fetched word.
package prog_mem_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int PC_W = 13;
  localparam int PAGE_W = 8;
  localparam int PAGE_WORDS = 256;
  localparam int WORDS_2K = 2048;
  localparam int WORDS_4K = 4096;
  localparam int WORDS_8K = 8192;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [BYTE_W-1:0] SECTOR_ZERO = 8'h00;
  localparam int EE_ADDR_W = 8;
  // Four system clocks form one instruction cycle; the fetch, programming and table phases each own the memory port.
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_PROG = 2'h1;
  localparam logic [1:0] PH_TABLE = 2'h2;
  localparam logic [1:0] PH_END = 2'h3;
  // Link frame: command, address, data, most significant bit first.
  localparam int FRAME_BITS = 32;
  localparam int RESP_BITS = 16;
  localparam int CMD_POS = 30;
  localparam int ADDR_POS = 16;
  localparam int ADDR_FIELD_W = 14;
  localparam logic [5:0] FRAME_LAST = 6'h1f;
  localparam logic [5:0] RESP_LAST = 6'h0f;
  typedef enum logic [1:0] {
    TBL_FULL = 2'h0,
    TBL_PAGE = 2'h1,
    TBL_LAST = 2'h2
  } tbl_op_t;
  typedef enum logic [1:0] {
    CMD_WR_FLASH = 2'h0,
    CMD_WR_EE = 2'h1,
    CMD_RD_FLASH = 2'h2,
    CMD_RD_DEBUG = 2'h3
  } link_cmd_t;
  typedef enum logic [1:0] {
    LINK_RX = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_TX = 2'b11
  } link_state_t;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_READ = 2'b01
  } tbl_state_t;
endpackage

// ---- hw/prog_word_mem.sv ----
// Single-port program word memory with registered read data.
`timescale 1ns/1ns
module prog_word_mem #(
  parameter int DEPTH = 8192,
  parameter int AW = 13,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end
endmodule

// ---- hw/serial_prog_link.sv ----
// Serial programming and debug link logic on the programmer's clock.
`timescale 1ns/1ns
module serial_prog_link import prog_mem_pkg::*; (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic mode_pin,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  output logic [FRAME_BITS-1:0] req_word,
  output logic req_toggle,
  input wire logic [RESP_BITS-1:0] resp_word,
  input wire logic resp_toggle
);
  logic rst_s1, rst_s2, mode_s1, mode_s2, resp_s1, resp_s2, resp_seen;
  logic link_rst;
  link_state_t state_reg;
  logic [5:0] count_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [RESP_BITS-1:0] tx_reg;

  always_ff @(posedge link_clk) begin
    rst_s1 <= rst;
    rst_s2 <= rst_s1;
    mode_s1 <= mode_pin;
    mode_s2 <= mode_s1;
    resp_s1 <= resp_toggle;
    resp_s2 <= resp_s1;
  end

  // Leaving programming mode also abandons any partial frame.
  assign link_rst = rst_s2 || !mode_s2;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= LINK_RX;
      count_reg <= 6'h00;
      shift_reg <= '0;
      tx_reg <= '0;
      req_word <= '0;
      req_toggle <= 1'b0;
      // Track the answer toggle so that a stale toggle is not taken as a fresh answer.
      resp_seen <= resp_s2;
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      case (state_reg)
        LINK_RX: begin
          // The edge that releases the line after an answer is not a frame bit.
          if (!data_oe) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], data_in};
            count_reg <= count_reg + 6'h01;
            if (count_reg == FRAME_LAST) begin
              count_reg <= 6'h00;
              req_word <= {shift_reg[FRAME_BITS-2:0], data_in};
              req_toggle <= ~req_toggle;
              if (shift_reg[FRAME_BITS-2]) begin
                state_reg <= LINK_WAIT;
              end
            end
          end
        end
        LINK_WAIT: begin
          if (resp_s2 != resp_seen) begin
            resp_seen <= resp_s2;
            tx_reg <= resp_word;
            state_reg <= LINK_TX;
          end
        end
        LINK_TX: begin
          data_oe <= 1'b1;
          data_out <= tx_reg[RESP_BITS-1];
          tx_reg <= {tx_reg[RESP_BITS-2:0], 1'b0};
          count_reg <= count_reg + 6'h01;
          if (count_reg == RESP_LAST) begin
            count_reg <= 6'h00;
            state_reg <= LINK_RX;
          end
        end
        default: begin
          state_reg <= LINK_RX;
        end
      endcase
      if (state_reg != LINK_TX) begin
        data_oe <= 1'b0;
        data_out <= 1'b0;
      end
    end
  end
endmodule

// ---- hw/program_memory_table_read.sv ----
// Program memory access unit: fetch, table reads and serial programming.
`timescale 1ns/1ns
module program_memory_table_read import prog_mem_pkg::*; #(
  parameter int VARIANT_WORDS = WORDS_8K,
  parameter bit DEBUG_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe,
  input wire logic prog_mode_pin,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic tbl_req,
  input wire logic [1:0] tbl_op,
  input wire logic tbl_long,
  input wire logic [2*BYTE_W-1:0] tbl_dest,
  input wire logic ptr_low_we,
  input wire logic ptr_high_we,
  input wire logic thb_we,
  input wire logic [BYTE_W-1:0] core_wdata,
  output logic [WORD_W-1:0] instr_word,
  output logic instr_valid,
  output logic [PC_W-1:0] instr_addr,
  output logic tbl_busy,
  output logic dm_wr_en,
  output logic [2*BYTE_W-1:0] dm_wr_addr,
  output logic [BYTE_W-1:0] dm_wr_data,
  output logic [BYTE_W-1:0] table_high_byte_hold,
  output logic ee_wr_en,
  output logic [EE_ADDR_W-1:0] ee_wr_addr,
  output logic [BYTE_W-1:0] ee_wr_data,
  output logic shared_pin_func_en,
  output logic prog_active
);
  localparam logic [PC_W-1:0] ADDR_MASK = PC_W'(VARIANT_WORDS - 1);
  localparam logic [PC_W-1:0] LAST_PAGE = PC_W'(VARIANT_WORDS - PAGE_WORDS);
  localparam int HIGH_W = PC_W - PAGE_W;

  logic [1:0] phase_reg;
  logic [PC_W-1:0] pc_reg;
  logic [WORD_W-1:0] fetch_word_reg;
  logic squash_reg;
  tbl_state_t tbl_state_reg;
  logic [PC_W-1:0] tbl_addr_reg;
  logic [2*BYTE_W-1:0] tbl_dest_reg;
  logic [BYTE_W-1:0] ptr_low_reg;
  logic [BYTE_W-1:0] ptr_high_reg;
  logic mode_s1, mode_s2;
  logic req_s1, req_s2, req_s3;
  logic [FRAME_BITS-1:0] link_req_word;
  logic link_req_toggle;
  logic [FRAME_BITS-1:0] prog_word_reg;
  logic prog_pend_reg;
  logic rd_back_reg;
  logic [RESP_BITS-1:0] resp_word_reg;
  logic resp_toggle_reg;
  logic [PC_W-1:0] mem_addr;
  logic mem_we;
  logic [WORD_W-1:0] mem_rdata;
  logic req_edge;
  logic tbl_start;
  logic [PC_W-1:0] tbl_addr_next;
  link_cmd_t prog_cmd;
  logic [PC_W-1:0] prog_addr;

  // Programming mode entry arrives on a pin and is synchronised first.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= prog_mode_pin;
      mode_s2 <= mode_s1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_active <= 1'b0;
    end else begin
      prog_active <= mode_s2;
    end
  end

  // Shared pin functions are released while programming and always in the debug part.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shared_pin_func_en <= !DEBUG_VARIANT;
    end else begin
      shared_pin_func_en <= !(DEBUG_VARIANT || mode_s2);
    end
  end

  // Instruction cycle phase counter.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_reg <= PH_FETCH;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign tbl_start = (tbl_state_reg == TS_IDLE) && tbl_req && !prog_active;
  assign prog_cmd = link_cmd_t'(prog_word_reg[FRAME_BITS-1:CMD_POS]);
  assign prog_addr = prog_word_reg[ADDR_POS+PC_W-1:ADDR_POS] & ADDR_MASK;

  // Table address forming per addressing form.
  always_comb begin
    tbl_addr_next = {ptr_high_reg[HIGH_W-1:0], ptr_low_reg} & ADDR_MASK;
    case (tbl_op_t'(tbl_op))
      TBL_FULL: begin
        tbl_addr_next = {ptr_high_reg[HIGH_W-1:0], ptr_low_reg} & ADDR_MASK;
      end
      TBL_PAGE: begin
        tbl_addr_next = {pc_reg[PC_W-1:PAGE_W], ptr_low_reg};
      end
      TBL_LAST: begin
        tbl_addr_next = LAST_PAGE | {{HIGH_W{1'b0}}, ptr_low_reg};
      end
      default: begin
        tbl_addr_next = {ptr_high_reg[HIGH_W-1:0], ptr_low_reg} & ADDR_MASK;
      end
    endcase
  end

  // Memory port sharing: fetch, programming access, table read.
  always_comb begin
    mem_addr = pc_reg;
    mem_we = 1'b0;
    case (phase_reg)
      PH_FETCH: begin
        mem_addr = pc_reg;
      end
      PH_PROG: begin
        if (prog_pend_reg) begin
          mem_addr = prog_addr;
          mem_we = (prog_cmd == CMD_WR_FLASH);
        end
      end
      PH_TABLE: begin
        mem_addr = tbl_addr_reg;
      end
      default: begin
        mem_addr = pc_reg;
      end
    endcase
  end

  prog_word_mem #(
    .DEPTH(VARIANT_WORDS),
    .AW(PC_W),
    .DW(WORD_W)
  ) u_mem (
    .clk(ref_clk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(prog_word_reg[WORD_W-1:0]),
    .rdata(mem_rdata)
  );

  // Table pointer registers written by the core.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_low_reg <= 8'h00;
      ptr_high_reg <= 8'h00;
    end else begin
      if (ptr_low_we) begin
        ptr_low_reg <= core_wdata;
      end
      if (ptr_high_we) begin
        ptr_high_reg <= core_wdata;
      end
    end
  end

  // Fetched word is captured one clock after its address.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetch_word_reg <= 16'h0000;
    end else if (phase_reg == PH_PROG) begin
      fetch_word_reg <= mem_rdata;
    end
  end

  // Program counter, updated at the end of each instruction cycle; held while programming or when a table read starts.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_reg <= RESET_VECTOR;
    end else if (phase_reg == PH_END) begin
      if (prog_active || tbl_start) begin
        pc_reg <= pc_reg;
      end else if (tbl_state_reg == TS_READ) begin
        pc_reg <= (pc_reg + 13'h0001) & ADDR_MASK;
      end else if (pc_load) begin
        pc_reg <= pc_target & ADDR_MASK;
      end else begin
        pc_reg <= (pc_reg + 13'h0001) & ADDR_MASK;
      end
    end
  end

  // Issued word; a jump discards the word already fetched.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instr_word <= 16'h0000;
      instr_valid <= 1'b0;
      instr_addr <= RESET_VECTOR;
      squash_reg <= 1'b0;
    end else if (phase_reg == PH_END) begin
      instr_word <= fetch_word_reg;
      instr_addr <= pc_reg;
      squash_reg <= 1'b0;
      if (prog_active || tbl_start) begin
        instr_valid <= 1'b0;
      end else if (tbl_state_reg == TS_READ) begin
        instr_valid <= 1'b1;
      end else if (pc_load) begin
        instr_valid <= 1'b0;
        squash_reg <= 1'b1;
      end else begin
        instr_valid <= 1'b1;
      end
    end
  end

  // Table read sequencer: request cycle, then one extra cycle for the read.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tbl_state_reg <= TS_IDLE;
      tbl_addr_reg <= RESET_VECTOR;
      tbl_dest_reg <= 16'h0000;
      tbl_busy <= 1'b0;
    end else if (phase_reg == PH_END) begin
      case (tbl_state_reg)
        TS_IDLE: begin
          if (tbl_start) begin
            tbl_state_reg <= TS_READ;
            tbl_busy <= 1'b1;
            tbl_addr_reg <= tbl_addr_next;
            if (tbl_long) begin
              tbl_dest_reg <= tbl_dest;
            end else begin
              tbl_dest_reg <= {SECTOR_ZERO, tbl_dest[BYTE_W-1:0]};
            end
          end
        end
        TS_READ: begin
          tbl_state_reg <= TS_IDLE;
          tbl_busy <= 1'b0;
        end
        default: begin
          tbl_state_reg <= TS_IDLE;
          tbl_busy <= 1'b0;
        end
      endcase
    end
  end

  // Low byte goes to data memory at the end of the read cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dm_wr_en <= 1'b0;
      dm_wr_addr <= 16'h0000;
      dm_wr_data <= 8'h00;
    end else if (phase_reg == PH_END && tbl_state_reg == TS_READ) begin
      dm_wr_en <= 1'b1;
      dm_wr_addr <= tbl_dest_reg;
      dm_wr_data <= mem_rdata[BYTE_W-1:0];
    end else begin
      dm_wr_en <= 1'b0;
    end
  end

  // High byte hold: the table load wins over a same-cycle software write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      table_high_byte_hold <= 8'h00;
    end else if (phase_reg == PH_END && tbl_state_reg == TS_READ) begin
      table_high_byte_hold <= mem_rdata[WORD_W-1:BYTE_W];
    end else if (thb_we) begin
      table_high_byte_hold <= core_wdata;
    end
  end

  serial_prog_link u_link (
    .link_clk(prog_serial_clock),
    .rst(rst),
    .mode_pin(prog_mode_pin),
    .data_in(prog_serial_data_in),
    .data_out(prog_serial_data_out),
    .data_oe(prog_serial_data_oe),
    .req_word(link_req_word),
    .req_toggle(link_req_toggle),
    .resp_word(resp_word_reg),
    .resp_toggle(resp_toggle_reg)
  );

  // Frame-done toggle crossing from the link clock.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= link_req_toggle;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  assign req_edge = req_s2 ^ req_s3;

  // Pending programming request; a new frame sets it even while it is served.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_word_reg <= '0;
      prog_pend_reg <= 1'b0;
    end else if (req_edge) begin
      prog_word_reg <= link_req_word;
      prog_pend_reg <= 1'b1;
    end else if (phase_reg == PH_PROG) begin
      prog_pend_reg <= 1'b0;
    end
  end

  // EEPROM writes are passed out as a one-cycle strobe.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ee_wr_en <= 1'b0;
      ee_wr_addr <= 8'h00;
      ee_wr_data <= 8'h00;
    end else if (phase_reg == PH_PROG && prog_pend_reg && prog_cmd == CMD_WR_EE) begin
      ee_wr_en <= 1'b1;
      ee_wr_addr <= prog_word_reg[ADDR_POS+EE_ADDR_W-1:ADDR_POS];
      ee_wr_data <= prog_word_reg[BYTE_W-1:0];
    end else begin
      ee_wr_en <= 1'b0;
    end
  end

  // Read answers go back to the link with a toggle; the word is stable first.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_back_reg <= 1'b0;
      resp_word_reg <= 16'h0000;
      resp_toggle_reg <= 1'b0;
    end else begin
      rd_back_reg <= 1'b0;
      if (phase_reg == PH_PROG && prog_pend_reg) begin
        if (prog_cmd == CMD_RD_FLASH) begin
          rd_back_reg <= 1'b1;
        end else if (prog_cmd == CMD_RD_DEBUG) begin
          resp_word_reg <= DEBUG_VARIANT ? {{(WORD_W-PC_W){1'b0}}, pc_reg} : 16'h0000;
          resp_toggle_reg <= ~resp_toggle_reg;
        end
      end
      if (rd_back_reg) begin
        resp_word_reg <= mem_rdata;
        resp_toggle_reg <= ~resp_toggle_reg;
      end
    end
  end
endmodule

// ---- verif/program_memory_table_read_properties.sv ----
// Concurrent checks on the ports of the program memory access unit.
`timescale 1ns/1ns
module program_memory_table_read_properties import prog_mem_pkg::*; #(
  parameter bit DEBUG_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_oe,
  input wire logic prog_active,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic tbl_req,
  input wire logic tbl_long,
  input wire logic [2*BYTE_W-1:0] tbl_dest,
  input wire logic thb_we,
  input wire logic [BYTE_W-1:0] core_wdata,
  input wire logic instr_valid,
  input wire logic [PC_W-1:0] instr_addr,
  input wire logic tbl_busy,
  input wire logic dm_wr_en,
  input wire logic [2*BYTE_W-1:0] dm_wr_addr,
  input wire logic [BYTE_W-1:0] table_high_byte_hold,
  input wire logic ee_wr_en,
  input wire logic shared_pin_func_en
);
  reset_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> ##4 (instr_valid && instr_addr == RESET_VECTOR))
    else $error("first fetch after reset is not at the reset entry");
  busy_span_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tbl_busy) |-> tbl_busy[*4] ##1 (!tbl_busy && dm_wr_en))
    else $error("table read does not finish after one extra cycle");
  dummy_slot_a: assert property (@(posedge ref_clk) disable iff (rst)
    tbl_busy |-> !instr_valid)
    else $error("instruction issued during table cycle");
  dest_sector_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tbl_busy) |-> ##4 (dm_wr_addr[15:8] ==
      ($past(tbl_long, 5) ? $past(tbl_dest[15:8], 5) : SECTOR_ZERO)))
    else $error("table destination sector wrong");
  dest_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tbl_busy) |-> ##4 (dm_wr_addr[7:0] == $past(tbl_dest[7:0], 5)))
    else $error("table destination address wrong");
  soft_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    thb_we ##1 !dm_wr_en |-> table_high_byte_hold == $past(core_wdata))
    else $error("software write of hold register lost");
  jump_target_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(instr_valid) && $past(pc_load) && !$past(tbl_req) && !$past(prog_active)
      |-> ##4 (instr_valid && instr_addr == $past(pc_target, 5)))
    else $error("jump target not fetched after one dummy cycle");
  dm_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    dm_wr_en |=> !dm_wr_en)
    else $error("data write strobe longer than one clock");
  ee_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    ee_wr_en |=> !ee_wr_en)
    else $error("eeprom write strobe longer than one clock");
  shared_pins_a: assert property (@(posedge ref_clk) disable iff (rst)
    (prog_active || DEBUG_VARIANT) |-> !shared_pin_func_en)
    else $error("shared pin functions left on");
  answer_span_a: assert property (@(posedge prog_serial_clock) disable iff (rst)
    $rose(prog_serial_data_oe) |-> prog_serial_data_oe[*8] ##1 prog_serial_data_oe[*8]
      ##1 !prog_serial_data_oe)
    else $error("answer drive length wrong");
endmodule
bind program_memory_table_read program_memory_table_read_properties #(
  .DEBUG_VARIANT(DEBUG_VARIANT)
) u_props (.ref_clk(ref_clk), .rst(rst), .prog_serial_clock(prog_serial_clock),
  .prog_serial_data_oe(prog_serial_data_oe), .prog_active(prog_active), .pc_load(pc_load),
  .pc_target(pc_target), .tbl_req(tbl_req), .tbl_long(tbl_long), .tbl_dest(tbl_dest),
  .thb_we(thb_we), .core_wdata(core_wdata), .instr_valid(instr_valid),
  .instr_addr(instr_addr), .tbl_busy(tbl_busy), .dm_wr_en(dm_wr_en),
  .dm_wr_addr(dm_wr_addr), .table_high_byte_hold(table_high_byte_hold),
  .ee_wr_en(ee_wr_en), .shared_pin_func_en(shared_pin_func_en));

// ---- verif/serial_programmer_model.sv ----
// Behavioural serial programmer driving the link clock, data line and mode pin.
`timescale 1ns/1ns
module serial_programmer_model (
  output logic link_clk,
  output logic mode,
  output logic data_drv,
  input wire logic line,
  input wire logic dev_oe
);
  initial begin
    link_clk = 1'b0;
    mode = 1'b0;
    data_drv = 1'b1;
  end
  // The link clock only runs inside these tasks: mode entry, mode exit and transfers.
  task automatic tick();
    #3 link_clk = 1'b1;
    #3 link_clk = 1'b0;
  endtask
  // Clocking with the mode pin low first brings the link logic out of its unknown state.
  task automatic enter();
    mode = 1'b0;
    repeat (3) tick();
    mode = 1'b1;
    repeat (2) tick();
  endtask
  task automatic leave();
    mode = 1'b0;
    repeat (3) tick();
  endtask
  task automatic frame(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      data_drv = f[i];
      tick();
    end
    data_drv = ~f[0];
  endtask
  // Keeps clocking until the device has driven its 16 answer bits, sampled mid-bit.
  task automatic read(input logic [31:0] f, output logic [15:0] r);
    int n;
    n = 0;
    r = 16'hxxxx;
    frame(f);
    for (int k = 0; k < 300 && n < 16; k++) begin
      data_drv = ~data_drv;
      tick();
      if (dev_oe === 1'b1) begin
        r = {r[14:0], line};
        n++;
      end
    end
    // One more edge lets the device release the line before the next frame.
    tick();
  endtask
endmodule

// ---- verif/program_memory_table_read_bench.sv ----
// Self-checking testbench for the program memory access unit.
`timescale 1ns/1ns
module program_memory_table_read_bench import prog_mem_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pc_load = 1'b0;
  logic [PC_W-1:0] pc_target = 13'h0000;
  logic tbl_req = 1'b0;
  logic [1:0] tbl_op = 2'h0;
  logic tbl_long = 1'b0;
  logic [15:0] tbl_dest = 16'h0000;
  logic ptr_low_we = 1'b0;
  logic ptr_high_we = 1'b0;
  logic thb_we = 1'b0;
  logic [7:0] core_wdata = 8'h00;
  logic [7:0] ee_addr_seen = 8'h00;
  logic [7:0] ee_data_seen = 8'h00;
  int errors = 0;
  int check_count = 0;
  wire logic link_clk, mode_pin, drv, dout, doe, line;
  wire logic instr_valid, tbl_busy, dm_wr_en, ee_wr_en, shared_en, prog_active;
  wire logic [15:0] instr_word, dm_wr_addr;
  wire logic [PC_W-1:0] instr_addr;
  wire logic [7:0] dm_wr_data, hold, ee_wr_addr, ee_wr_data;
  assign line = doe ? dout : drv;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (ee_wr_en === 1'b1) begin
      ee_addr_seen <= ee_wr_addr;
      ee_data_seen <= ee_wr_data;
    end
  end
  program_memory_table_read u_program_memory_table_read (.ref_clk(ref_clk), .rst(rst),
    .prog_serial_clock(link_clk), .prog_serial_data_in(line), .prog_serial_data_out(dout),
    .prog_serial_data_oe(doe), .prog_mode_pin(mode_pin), .pc_load(pc_load),
    .pc_target(pc_target), .tbl_req(tbl_req), .tbl_op(tbl_op), .tbl_long(tbl_long),
    .tbl_dest(tbl_dest), .ptr_low_we(ptr_low_we), .ptr_high_we(ptr_high_we),
    .thb_we(thb_we), .core_wdata(core_wdata), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_addr(instr_addr), .tbl_busy(tbl_busy),
    .dm_wr_en(dm_wr_en), .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data),
    .table_high_byte_hold(hold), .ee_wr_en(ee_wr_en), .ee_wr_addr(ee_wr_addr),
    .ee_wr_data(ee_wr_data), .shared_pin_func_en(shared_en), .prog_active(prog_active));
  serial_programmer_model u_prog (.link_clk(link_clk), .mode(mode_pin), .data_drv(drv),
    .line(line), .dev_oe(doe));
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    rst = 1'b1;
    repeat (2) step();
    rst = 1'b0;
    repeat (4) step();
    cmp("instr_valid", 16'h0001, {15'h0, instr_valid});
    cmp("instr_addr", {3'h0, RESET_VECTOR}, {3'h0, instr_addr});
  endtask
  task automatic t_link();
    logic [15:0] r;
    u_prog.enter();
    u_prog.frame({2'h0, 14'h0f06, 16'h121a});
    repeat (20) step();
    u_prog.frame({2'h0, 14'h0f05, 16'h340f});
    repeat (20) step();
    u_prog.frame({2'h0, 14'h1f02, 16'h5678});
    repeat (20) step();
    u_prog.frame({2'h1, 14'h005a, 16'h003c});
    repeat (20) step();
    cmp("ee_wr_addr", 16'h005a, {8'h0, ee_addr_seen});
    cmp("ee_wr_data", 16'h003c, {8'h0, ee_data_seen});
    cmp("shared_pin_func_en", 16'h0000, {15'h0, shared_en});
    cmp("prog_active", 16'h0001, {15'h0, prog_active});
    u_prog.read({2'h2, 14'h0f06, 16'h0000}, r);
    cmp("flash readback", 16'h121a, r);
    u_prog.read({2'h3, 14'h0000, 16'h0000}, r);
    cmp("debug read", 16'h0000, r);
    u_prog.leave();
    repeat (10) step();
    cmp("shared_pin_func_en", 16'h0001, {15'h0, shared_en});
    cmp("prog_active", 16'h0000, {15'h0, prog_active});
  endtask
  task automatic t_table(input logic [1:0] op, input logic lng, input logic [15:0] dest,
      input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] exp_dest,
      input logic [15:0] word);
    core_wdata = lo;
    ptr_low_we = 1'b1;
    step();
    ptr_low_we = 1'b0;
    core_wdata = hi;
    ptr_high_we = 1'b1;
    step();
    ptr_high_we = 1'b0;
    tbl_op = op;
    tbl_long = lng;
    tbl_dest = dest;
    // No software hold write is driven while a table read is in flight.
    tbl_req = 1'b1;
    for (int i = 0; i < 20 && tbl_busy !== 1'b1; i++) step();
    tbl_req = 1'b0;
    cmp("dummy slot", 16'h0000, {15'h0, instr_valid});
    for (int i = 0; i < 20 && dm_wr_en !== 1'b1; i++) step();
    cmp("dm_wr_en", 16'h0001, {15'h0, dm_wr_en});
    cmp("dm_wr_addr", exp_dest, dm_wr_addr);
    cmp("dm_wr_data", {8'h0, word[7:0]}, {8'h0, dm_wr_data});
    cmp("hold", {8'h0, word[15:8]}, {8'h0, hold});
  endtask
  task automatic t_jump(input logic [PC_W-1:0] tgt, input logic [15:0] word);
    for (int i = 0; i < 20 && instr_valid !== 1'b1; i++) step();
    pc_target = tgt;
    pc_load = 1'b1;
    for (int i = 0; i < 20 && instr_valid !== 1'b0; i++) step();
    pc_load = 1'b0;
    for (int i = 0; i < 20 && instr_valid !== 1'b1; i++) step();
    cmp("jump addr", {3'h0, tgt}, {3'h0, instr_addr});
    cmp("jump word", word, instr_word);
  endtask
  task automatic t_soft_hold();
    core_wdata = 8'h77;
    thb_we = 1'b1;
    step();
    thb_we = 1'b0;
    cmp("hold write", 16'h0077, {8'h0, hold});
  endtask
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    t_reset();
    t_link();
    t_table(TBL_FULL, 1'b0, 16'h1280, 8'h06, 8'h0f, 16'h0080, 16'h121a);
    t_table(TBL_FULL, 1'b1, 16'h0381, 8'h05, 8'h0f, 16'h0381, 16'h340f);
    t_table(TBL_LAST, 1'b0, 16'h0090, 8'h02, 8'h00, 16'h0090, 16'h5678);
    t_jump(13'h0f05, 16'h340f);
    t_table(TBL_PAGE, 1'b0, 16'h0091, 8'h06, 8'h00, 16'h0091, 16'h121a);
    t_soft_hold();
    t_reset();
    complete_run();
  end
endmodule
